// ==== inc/rfc_pkg.sv ====
// Shared constants and carrier types of the compensated RTC divider block.
package rfc_pkg;
    // Register offsets of the register port.
    localparam logic [7:0] ADR_CTRL1 = 8'h00;
    localparam logic [7:0] ADR_INT_EN = 8'h01;
    localparam logic [7:0] ADR_INT_FLAG = 8'h02;
    localparam logic [7:0] ADR_STATUS = 8'h03;
    localparam logic [7:0] ADR_TMR_LO = 8'h18;
    localparam logic [7:0] ADR_TMR_HI = 8'h19;
    localparam logic [7:0] ADR_TEMP = 8'h20;
    localparam logic [7:0] ADR_CAL = 8'h30;
    localparam logic [7:0] ADR_XOFF = 8'h31;
    localparam logic [7:0] ADR_XCOEF = 8'h32;
    localparam logic [7:0] ADR_XT0 = 8'h33;
    // Bit positions.
    localparam int B_RUN = 1;
    localparam int B_RELOAD = 2;
    localparam int B_SRC_LO = 5;
    localparam int B_SRC_HI = 6;
    localparam int B_TIRQ = 1;
    localparam int B_LOWSUP = 5;
    localparam int B_SCAN = 0;
    localparam int B_THERM = 1;
    localparam int B_FD_LO = 2;
    localparam int B_FD_HI = 3;
    localparam int B_SIGN = 7;
    localparam int T0_W = 6;
    // Compensation constants.
    localparam logic [9:0] T0_BIAS = 10'h004;
    localparam logic [9:0] TEMP_BIAS = 10'h03C;
    localparam int COEF_SHIFT = 12;
    localparam int PERIOD_S = 32;
    localparam int XTAL_HZ = 32768;
    localparam logic [3:0] SCAN_LONG_S = 4'hF;
    // Divider chain taps.
    localparam int DIV_W = 15;
    localparam int BIT_1024 = 4;
    localparam int BIT_32 = 9;
    localparam int BIT_8 = 11;
    localparam int BIT_1 = 14;
    // Selector codes.
    localparam logic [1:0] SEL_A = 2'h0;
    localparam logic [1:0] SEL_B = 2'h1;
    localparam logic [1:0] SEL_C = 2'h2;
    localparam logic [1:0] SEL_D = 2'h3;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rfc_reg_req_s;
    typedef struct packed {
        logic hz1024;
        logic hz32;
        logic hz8;
        logic hz1;
    } rfc_ticks_s;
endpackage

// ==== logic/rfc_divider.sv ====
// Compensated divider chain fed by crystal ticks with add and remove steps.
`timescale 1ns/1ps
module rfc_divider (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic tick_i,
    input wire logic add_i,
    input wire logic remove_i,
    output logic [rfc_pkg::DIV_W-1:0] cnt_o,
    output rfc_pkg::rfc_ticks_s ticks_o
);
    typedef struct packed {
        logic [rfc_pkg::DIV_W-1:0] cnt;
        rfc_pkg::rfc_ticks_s ticks;
    } rfc_div_s;
    rfc_div_s st;
    rfc_div_s next_st;
    logic [rfc_pkg::DIV_W-1:0] step;
    logic [rfc_pkg::DIV_W-1:0] nc;

    // An added clock advances by two, a removed one holds the chain.
    always_comb begin
        next_st = st;
        step = '0;
        if (tick_i) begin
            step = add_i ? 15'h0002 : (remove_i ? 15'h0000 : 15'h0001);
        end
        nc = st.cnt + step;
        next_st.cnt = nc;
        next_st.ticks.hz1024 = st.cnt[rfc_pkg::BIT_1024] & ~nc[rfc_pkg::BIT_1024];
        next_st.ticks.hz32 = st.cnt[rfc_pkg::BIT_32] & ~nc[rfc_pkg::BIT_32];
        next_st.ticks.hz8 = st.cnt[rfc_pkg::BIT_8] & ~nc[rfc_pkg::BIT_8];
        next_st.ticks.hz1 = st.cnt[rfc_pkg::BIT_1] & ~nc[rfc_pkg::BIT_1];
    end

    // State register.
    always_ff @(posedge clock_i) begin
        st <= srst_i ? '0 : next_st;
    end

    assign cnt_o = st.cnt;
    assign ticks_o = st.ticks;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);
    add_step_a: assert property (
        tick_i && add_i |=> st.cnt == $past(st.cnt) + 15'h0002)
        else $error("Added clock did not advance by two.");
    drop_step_a: assert property (tick_i && remove_i && !add_i |=> $stable(st.cnt))
        else $error("Removed clock still advanced the chain.");
endmodule // rfc_divider

// ==== logic/rfc_timer.sv ====
// Countdown timer run from the compensated source clocks.
`timescale 1ns/1ps
module rfc_timer (
    input wire logic clock_i,
    input wire logic srst_i,
    input rfc_pkg::rfc_ticks_s ticks_i,
    input wire logic run_i,
    input wire logic reload_i,
    input wire logic [1:0] src_i,
    input wire logic [15:0] value_i,
    output logic expire_o
);
    typedef struct packed {
        logic [15:0] cnt;
        logic active;
        logic run_d;
        logic expire;
    } rfc_tmr_s;
    rfc_tmr_s st;
    rfc_tmr_s next_st;
    logic src_tick;

    // Source select, then count n+1 source ticks per expiry.
    always_comb begin
        next_st = st;
        next_st.expire = 1'b0;
        next_st.run_d = run_i;
        unique case (src_i)
            rfc_pkg::SEL_A: src_tick = ticks_i.hz32;
            rfc_pkg::SEL_B: src_tick = ticks_i.hz8;
            rfc_pkg::SEL_C: src_tick = ticks_i.hz1;
            rfc_pkg::SEL_D: src_tick = ticks_i.hz1;
        endcase
        if (!run_i) begin
            next_st.active = 1'b0;
        end else if (!st.run_d) begin
            next_st.cnt = value_i;
            next_st.active = 1'b1;
        end else if (st.active && src_tick) begin
            if (st.cnt == 16'h0000) begin
                next_st.expire = 1'b1;
                next_st.cnt = value_i;
                next_st.active = reload_i;
            end else begin
                next_st.cnt = st.cnt - 16'h0001;
            end
        end
    end

    // State register.
    always_ff @(posedge clock_i) begin
        st <= srst_i ? '0 : next_st;
    end

    assign expire_o = st.expire;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);
    reload_value_a: assert property (
        st.expire && $past(reload_i) |-> st.active && st.cnt == $past(value_i))
        else $error("Auto-reload did not restore the count.");
    tmr_cover: cover property (st.expire ##1 !st.expire [*8] ##1 st.active);
endmodule // rfc_timer

// ==== logic/rfc_comp_top.sv ====
// Temperature driven frequency compensation, clock output and timer interrupt.
`timescale 1ns/1ps
module rfc_comp_top #(
    parameter int PERIOD_TICKS = rfc_pkg::PERIOD_S * rfc_pkg::XTAL_HZ,
    parameter int SECOND_TICKS = rfc_pkg::XTAL_HZ,
    parameter logic [7:0] XOFF_RST = 8'h00,
    parameter logic [7:0] XCOEF_RST = 8'h00,
    parameter logic [7:0] XT0_RST = 8'h15
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic xtal_i,
    input wire logic low_supply_i,
    input wire logic [7:0] temp_code_i,
    input wire logic temp_valid_i,
    input rfc_pkg::rfc_reg_req_s reg_req_i,
    output logic [7:0] reg_rdata_o,
    output logic temp_req_o,
    output logic clock_output_pin_o,
    output logic int_n_o
);
    localparam int PW = $clog2(PERIOD_TICKS + 1);
    localparam int SW = $clog2(SECOND_TICKS + 1);
    localparam logic [PW-1:0] PERIOD_LAST = PW'(PERIOD_TICKS - 1);
    localparam logic [PW:0] PERIOD_FULL = (PW + 1)'(PERIOD_TICKS);
    localparam logic [SW-1:0] SECOND_LAST = SW'(SECOND_TICKS - 1);

    typedef enum logic [1:0] {FCU_WAIT, FCU_SQUARE, FCU_SCALE} rfc_fcu_e;

    typedef struct packed {
        logic xs1;
        logic xs2;
        logic xs3;
        logic ls1;
        logic ls2;
        logic raw_tick;
        logic add;
        logic remove;
        logic [7:0] ctrl1;
        logic int_en;
        logic int_flag;
        logic lowsup;
        logic [7:0] tmr_lo;
        logic [7:0] tmr_hi;
        logic [7:0] temp;
        logic [7:0] cal;
        logic [7:0] xoff;
        logic [7:0] xcoef;
        logic [rfc_pkg::T0_W-1:0] xt0;
        logic [7:0] rdata;
        logic [PW-1:0] period_cnt;
        logic [SW-1:0] sec_cnt;
        logic [3:0] scan_cnt;
        logic temp_req;
        rfc_fcu_e freq_comp_unit;
        logic [19:0] dsq;
        logic corr_pos;
        logic [15:0] corr_mag;
        logic [PW-1:0] acc;
        logic clock_output_pin;
        logic int_n;
    } rfc_main_s;

    rfc_main_s st;
    rfc_main_s next_st;
    rfc_pkg::rfc_ticks_s ticks;
    logic [rfc_pkg::DIV_W-1:0] dcnt;
    logic expire;

    logic wr;
    logic [7:0] wa;
    logic [7:0] wd;
    logic [9:0] dt;
    logic [27:0] drift_full;
    logic [15:0] drift;
    logic [15:0] off_mag;
    logic [16:0] diff;
    logic [PW:0] acc_sum;
    logic scan_due;
    logic therm_live;

    assign wr = reg_req_i.wr;
    assign wa = reg_req_i.addr;
    assign wd = reg_req_i.wdata;

    // Compensated divider chain.
    rfc_divider u_div (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .tick_i(st.raw_tick),
        .add_i(st.add),
        .remove_i(st.remove),
        .cnt_o(dcnt),
        .ticks_o(ticks)
    );

    // Countdown timer on the compensated source clocks.
    rfc_timer u_tmr (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .ticks_i(ticks),
        .run_i(st.ctrl1[rfc_pkg::B_RUN]),
        .reload_i(st.ctrl1[rfc_pkg::B_RELOAD]),
        .src_i({st.ctrl1[rfc_pkg::B_SRC_HI], st.ctrl1[rfc_pkg::B_SRC_LO]}),
        .value_i({st.tmr_hi, st.tmr_lo}),
        .expire_o(expire)
    );

    // Next state of every register of the block.
    always_comb begin
        next_st = st;
        dt = '0;
        drift_full = '0;
        drift = '0;
        off_mag = '0;
        diff = '0;
        acc_sum = '0;
        scan_due = 1'b0;
        // Pin synchronisers; the first stage feeds only the second.
        next_st.xs1 = xtal_i;
        next_st.xs2 = st.xs1;
        next_st.xs3 = st.xs2;
        next_st.ls1 = low_supply_i;
        next_st.ls2 = st.ls1;
        next_st.raw_tick = st.xs2 & ~st.xs3;
        next_st.add = 1'b0;
        next_st.remove = 1'b0;
        next_st.temp_req = 1'b0;
        therm_live = st.cal[rfc_pkg::B_THERM] & ~st.lowsup;

        // Register writes.
        if (wr) begin
            unique case (wa)
                rfc_pkg::ADR_CTRL1: next_st.ctrl1 = wd;
                rfc_pkg::ADR_INT_EN: next_st.int_en = wd[rfc_pkg::B_TIRQ];
                rfc_pkg::ADR_INT_FLAG: begin
                    if (!wd[rfc_pkg::B_TIRQ]) begin
                        next_st.int_flag = 1'b0;
                    end
                end
                rfc_pkg::ADR_STATUS: begin
                    if (!wd[rfc_pkg::B_LOWSUP]) begin
                        next_st.lowsup = 1'b0;
                    end
                end
                rfc_pkg::ADR_TMR_LO: next_st.tmr_lo = wd;
                rfc_pkg::ADR_TMR_HI: next_st.tmr_hi = wd;
                rfc_pkg::ADR_TEMP: begin
                    if (!st.cal[rfc_pkg::B_THERM]) begin
                        next_st.temp = wd;
                    end
                end
                rfc_pkg::ADR_CAL: next_st.cal = wd;
                rfc_pkg::ADR_XOFF: next_st.xoff = wd;
                rfc_pkg::ADR_XCOEF: next_st.xcoef = wd;
                rfc_pkg::ADR_XT0: next_st.xt0 = wd[rfc_pkg::T0_W-1:0];
                default: ;
            endcase
        end

        // Hardware sets win over software clears.
        // A clear that lands in the event cycle would otherwise lose the event.
        if (expire) begin
            next_st.int_flag = 1'b1;
        end
        if (st.ls2) begin
            next_st.lowsup = 1'b1;
        end

        // Thermometer scan timing in raw crystal seconds.
        if (st.raw_tick) begin
            if (st.sec_cnt == SECOND_LAST) begin
                next_st.sec_cnt = '0;
                scan_due = st.cal[rfc_pkg::B_SCAN] ? (st.scan_cnt == rfc_pkg::SCAN_LONG_S) : 1'b1;
                next_st.scan_cnt = scan_due ? 4'h0 : st.scan_cnt + 4'h1;
            end else begin
                next_st.sec_cnt = st.sec_cnt + SW'(1);
            end
        end
        next_st.temp_req = scan_due & therm_live;
        if (temp_valid_i && therm_live) begin
            next_st.temp = temp_code_i;
        end

        // Compensation unit: squared distance, then scaled count.
        dt = {2'h0, st.temp} - ({4'h0, st.xt0} + rfc_pkg::T0_BIAS + rfc_pkg::TEMP_BIAS);
        drift_full = {8'h00, st.dsq} * {20'h00000, st.xcoef};
        drift = drift_full[rfc_pkg::COEF_SHIFT +: 16];
        off_mag = {9'h000, st.xoff[6:0]};
        if (st.xoff[rfc_pkg::B_SIGN]) begin
            diff = {1'b0, drift} - {1'b0, off_mag};
        end else begin
            diff = {1'b0, drift} + {1'b0, off_mag};
        end
        unique case (st.freq_comp_unit)
            FCU_WAIT: begin
                if (st.raw_tick && st.period_cnt == PERIOD_LAST) begin
                    next_st.freq_comp_unit = FCU_SQUARE;
                end
            end
            FCU_SQUARE: begin
                next_st.dsq = 20'(($signed(dt) * $signed(dt)));
                next_st.freq_comp_unit = FCU_SCALE;
            end
            FCU_SCALE: begin
                next_st.corr_pos = ~diff[16];
                next_st.corr_mag = diff[16] ? 16'(-diff) : diff[15:0];
                next_st.freq_comp_unit = FCU_WAIT;
            end
            default: next_st.freq_comp_unit = FCU_WAIT;
        endcase

        // Period counter in raw crystal ticks.
        if (st.raw_tick) begin
            next_st.period_cnt = (st.period_cnt == PERIOD_LAST) ? '0 : st.period_cnt + PW'(1);
        end

        // Even spreading of corrections. The divider only steps on a tick, so a correction
        // is registered together with the tick that is about to be registered; a step that
        // came one cycle after its tick would never reach the chain.
        if (next_st.raw_tick) begin
            acc_sum = {1'b0, st.acc} + (PW + 1)'(st.corr_mag);
            if (acc_sum >= PERIOD_FULL) begin
                next_st.acc = PW'(acc_sum - PERIOD_FULL);
                next_st.add = st.corr_pos;
                next_st.remove = ~st.corr_pos;
            end else begin
                next_st.acc = acc_sum[PW-1:0];
            end
        end

        // Clock output select.
        unique case ({st.cal[rfc_pkg::B_FD_HI], st.cal[rfc_pkg::B_FD_LO]})
            rfc_pkg::SEL_A: next_st.clock_output_pin = st.xs2;
            rfc_pkg::SEL_B: next_st.clock_output_pin = dcnt[rfc_pkg::BIT_1024];
            rfc_pkg::SEL_C: next_st.clock_output_pin = dcnt[rfc_pkg::BIT_32];
            rfc_pkg::SEL_D: next_st.clock_output_pin = dcnt[rfc_pkg::BIT_1];
        endcase

        // Active low interrupt pin follows flag and enable.
        next_st.int_n = ~(next_st.int_flag & next_st.int_en);

        // Read data.
        unique case (wa)
            rfc_pkg::ADR_CTRL1: next_st.rdata = st.ctrl1;
            rfc_pkg::ADR_INT_EN: next_st.rdata = 8'(st.int_en) << rfc_pkg::B_TIRQ;
            rfc_pkg::ADR_INT_FLAG: next_st.rdata = 8'(st.int_flag) << rfc_pkg::B_TIRQ;
            rfc_pkg::ADR_STATUS: next_st.rdata = 8'(st.lowsup) << rfc_pkg::B_LOWSUP;
            rfc_pkg::ADR_TMR_LO: next_st.rdata = st.tmr_lo;
            rfc_pkg::ADR_TMR_HI: next_st.rdata = st.tmr_hi;
            rfc_pkg::ADR_TEMP: next_st.rdata = st.temp;
            rfc_pkg::ADR_CAL: next_st.rdata = st.cal;
            rfc_pkg::ADR_XOFF: next_st.rdata = st.xoff;
            rfc_pkg::ADR_XCOEF: next_st.rdata = st.xcoef;
            rfc_pkg::ADR_XT0: next_st.rdata = {2'h0, st.xt0};
            default: next_st.rdata = 8'h00;
        endcase
    end

    // State register with calibration defaults at reset.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            st <= '0;
            st.xoff <= XOFF_RST;
            st.xcoef <= XCOEF_RST;
            st.xt0 <= XT0_RST[rfc_pkg::T0_W-1:0];
            st.int_n <= 1'b1;
            st.freq_comp_unit <= FCU_WAIT;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_o = st.rdata;
    assign temp_req_o = st.temp_req;
    assign clock_output_pin_o = st.clock_output_pin;
    assign int_n_o = st.int_n;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);
    t0_field_a: assert property (
        wr && wa == rfc_pkg::ADR_XT0 ##1 1'b1 ##1 1'b1
        |-> st.rdata[7:6] == 2'h0 || $past(wa) != rfc_pkg::ADR_XT0)
        else $error("Turnover register upper bits read nonzero.");
    recompute_a: assert property (
        st.raw_tick && st.period_cnt == PERIOD_LAST && st.freq_comp_unit == FCU_WAIT
        |=> st.freq_comp_unit == FCU_SQUARE ##1 st.freq_comp_unit == FCU_SCALE ##1 st.freq_comp_unit == FCU_WAIT)
        else $error("Compensation count not recomputed at period end.");
    step_sign_a: assert property (st.add |-> st.corr_pos && !st.remove)
        else $error("Correction direction disagrees with count sign.");
    step_on_tick_a: assert property (st.add || st.remove |-> st.raw_tick)
        else $error("Correction issued without a crystal tick.");
    raw_clock_output_pin_a: assert property (
        st.cal[rfc_pkg::B_FD_LO +: 2] == rfc_pkg::SEL_A && $stable(st.cal)
        |-> st.clock_output_pin == $past(st.xs2))
        else $error("Raw clock output does not follow the crystal.");
    scan_gate_a: assert property (
        st.temp_req |-> $past(st.cal[rfc_pkg::B_THERM]) && !$past(st.lowsup))
        else $error("Thermometer scanned while disabled or low supply.");
    temp_frozen_a: assert property (
        st.lowsup && !(wr && wa == rfc_pkg::ADR_TEMP) |=> $stable(st.temp))
        else $error("Temperature changed under low supply.");
    int_fall_a: assert property (
        expire && st.int_en && !(wr && wa == rfc_pkg::ADR_INT_EN) |=> !int_n_o)
        else $error("Interrupt pin did not fall on expiry.");
    int_release_a: assert property (
        wr && wa == rfc_pkg::ADR_INT_FLAG && !wd[rfc_pkg::B_TIRQ] && !expire |=> int_n_o)
        else $error("Flag clear did not release interrupt pin.");
    flag_set_wins_a: assert property (expire |=> st.int_flag)
        else $error("Timer flag lost to a clear in the expiry cycle.");
    int_mask_a: assert property (!st.int_en |-> int_n_o)
        else $error("Interrupt pin low with the timer interrupt disabled.");
    temp_lock_a: assert property (
        wr && wa == rfc_pkg::ADR_TEMP && st.cal[rfc_pkg::B_THERM] && !temp_valid_i
        |=> $stable(st.temp))
        else $error("Temperature write taken while the thermometer runs.");
    add_cover: cover property (st.add);
    remove_cover: cover property (st.remove);
    int_cover: cover property (!int_n_o ##1 int_n_o);
endmodule // rfc_comp_top

// ==== test/rfc_xtal_model.sv ====
// Partner model: free running crystal and a thermometer that answers scan requests.
`timescale 1ns/1ps
module rfc_xtal_model #(
    parameter int HALF = 2
) (
    input wire logic clock_i,
    input wire logic temp_req_i,
    input wire logic [7:0] code_i,
    output logic xtal_o,
    output logic [7:0] temp_code_o,
    output logic temp_valid_o
);
    int div = 0;
    int busy = 0;
    logic [7:0] last = 8'h00;
    initial begin
        xtal_o = 1'b0;
        temp_code_o = 8'hFF;
        temp_valid_o = 1'b0;
    end
    // The crystal never stops, so each rising edge is one raw reference tick.
    always @(posedge clock_i) begin
        div <= (div == HALF - 1) ? 0 : div + 1;
        if (div == HALF - 1) xtal_o <= ~xtal_o;
    end
    // A scan answers after a short conversion, one count per degree from -60 C.
    always @(posedge clock_i) begin
        temp_valid_o <= 1'b0;
        temp_code_o <= ~last; // No stale result is left on the code lines.
        if (temp_req_i === 1'b1) begin
            busy <= 3;
        end else if (busy == 1) begin
            temp_valid_o <= 1'b1;
            temp_code_o <= code_i;
            last <= code_i;
            busy <= 0;
        end else if (busy > 1) begin
            busy <= busy - 1;
        end
    end
endmodule // rfc_xtal_model

// ==== test/test_rfc_comp_top.sv ====
// Self-checking bench of the compensated divider, clock output and timer interrupt.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module test_rfc_comp_top;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic low_supply_i = 1'b0;
    rfc_pkg::rfc_reg_req_s req = '0;
    logic xtal, tvalid, temp_req, clk_out, int_n;
    logic [7:0] tcode, rdata, v, save;
    logic [7:0] code = 8'h40;
    int err_total = 0;
    int n_compared = 0;
    int seed = 32'h5326;
    int ticks = 0;
    int nedge = 0;
    int nreq = 0;
    int t1, t2, e;
    logic [1:0] sel_t [5] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h1};
    logic [7:0] off_t [5] = '{8'h20, 8'h00, 8'h20, 8'hA0, 8'h00};
    logic [7:0] coef_t [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
    // Clock generation.
    always #10 clock_i = ~clock_i;
    rfc_comp_top #(.PERIOD_TICKS(64), .SECOND_TICKS(8)) dut (.clock_i(clock_i),
        .srst_i(srst_i), .xtal_i(xtal), .low_supply_i(low_supply_i), .temp_code_i(tcode),
        .temp_valid_i(tvalid), .reg_req_i(req), .reg_rdata_o(rdata), .temp_req_o(temp_req),
        .clock_output_pin_o(clk_out), .int_n_o(int_n));
    rfc_xtal_model #(.HALF(2)) xm (.clock_i(clock_i), .temp_req_i(temp_req), .code_i(code),
        .xtal_o(xtal), .temp_code_o(tcode), .temp_valid_o(tvalid));
    // Event counters for raw ticks, clock output edges and scan requests.
    always @(posedge xtal) ticks++;
    always @(posedge clk_out) nedge++;
    always @(posedge clock_i) if (temp_req === 1'b1) nreq++;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        req <= '{wr: 1'b1, addr: a, wdata: d};
        @(posedge clock_i);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        req.addr <= a;
        @(posedge clock_i);
        #1 d = rdata;
    endtask
    task automatic wait_ticks(input int n);
        int s;
        s = ticks;
        while (ticks < s + n) @(posedge clock_i);
    endtask
    task automatic wait_low(output int t);
        int c;
        c = 0;
        while (int_n !== 1'b0 && c < 40000) begin
            @(posedge clock_i);
            c++;
        end
        t = ticks;
    endtask
    // Clock output edges over 256 raw ticks; temperature 101 is 16 C above turnover 15h.
    function automatic int exp_edges(input logic [1:0] sel, input logic [7:0] off,
                                     input logic [7:0] coef);
        int n;
        n = ((16 * 16 * int'(coef)) >> 12) + (off[7] ? -int'(off[6:0]) : int'(off[6:0]));
        return (sel == 2'h0) ? 256 : (256 + 4 * n) / 32;
    endfunction
    function automatic int near(input int x, input int g);
        return (g >= x - 1 && g <= x + 1) ? x : g;
    endfunction
    task automatic wrap_up();
        $display("Compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog against a hung handshake or a timer that never fires.
    initial begin
        repeat (60000) @(posedge clock_i);
        err_total++;
        wrap_up();
    end
    // Main sequence.
    initial begin
        repeat (5) @(posedge clock_i);
        srst_i <= 1'b0;
        rd(rfc_pkg::ADR_XT0, v);
        `CHK("turnover reset", 8'h15, v);
        `CHK("int idle", 1'b1, int_n);
        wr(rfc_pkg::ADR_XT0, 8'hFF);
        rd(rfc_pkg::ADR_XT0, v);
        `CHK("turnover width", 8'h3F, v);
        rd(8'h10, v);
        `CHK("unmapped", 8'h00, v);
        wr(rfc_pkg::ADR_XT0, 8'h15);
        wr(rfc_pkg::ADR_TEMP, 8'h65);
        rd(rfc_pkg::ADR_TEMP, v);
        `CHK("temp write", 8'h65, v);
        for (int i = 0; i < 5; i++) begin
            if (i == 4) off_t[4] = 8'(($random(seed) & 32'h1F) | ($random(seed) & 32'h80));
            wr(rfc_pkg::ADR_XCOEF, coef_t[i]);
            wr(rfc_pkg::ADR_XOFF, off_t[i]);
            wr(rfc_pkg::ADR_CAL, {4'h0, sel_t[i], 2'h0});
            wait_ticks(128);
            t1 = nedge;
            wait_ticks(256);
            e = exp_edges(sel_t[i], off_t[i], coef_t[i]);
            `CHK("clk edges", e, near(e, nedge - t1));
        end
        wr(rfc_pkg::ADR_XCOEF, 8'h00);
        wr(rfc_pkg::ADR_XOFF, 8'h00);
        code = 8'($random(seed));
        wr(rfc_pkg::ADR_CAL, 8'h02);
        wait_ticks(16);
        t1 = nreq;
        wait_ticks(64);
        `CHK("scan count", 8, near(8, nreq - t1));
        wr(rfc_pkg::ADR_TEMP, ~code);
        rd(rfc_pkg::ADR_TEMP, v);
        `CHK("temp scan", code, v);
        wr(rfc_pkg::ADR_CAL, 8'h03);
        wait_ticks(8);
        t1 = nreq;
        wait_ticks(256);
        `CHK("slow scan count", 2, near(2, nreq - t1));
        wr(rfc_pkg::ADR_CAL, 8'h02);
        save = code;
        wait_ticks(1);
        low_supply_i <= 1'b1;
        wait_ticks(2);
        code = ~code;
        t1 = nreq;
        wait_ticks(32);
        `CHK("scan stopped", 0, nreq - t1);
        rd(rfc_pkg::ADR_TEMP, v);
        `CHK("temp frozen", save, v);
        rd(rfc_pkg::ADR_STATUS, v);
        `CHK("low supply", 1'b1, v[5]);
        wr(rfc_pkg::ADR_CAL, 8'h00);
        wr(rfc_pkg::ADR_CTRL1, 8'h00);
        wr(rfc_pkg::ADR_CTRL1, 8'h20);
        wr(rfc_pkg::ADR_TMR_LO, 8'h00);
        wr(rfc_pkg::ADR_TMR_HI, 8'h00);
        wr(rfc_pkg::ADR_INT_EN, 8'h02);
        wr(rfc_pkg::ADR_CTRL1, 8'h24);
        wr(rfc_pkg::ADR_CTRL1, 8'h26);
        wait_low(t1);
        repeat (20) @(posedge clock_i);
        `CHK("int held", 1'b0, int_n);
        rd(rfc_pkg::ADR_INT_FLAG, v);
        `CHK("timer flag", 1'b1, v[1]);
        wr(rfc_pkg::ADR_INT_FLAG, 8'h00);
        @(posedge clock_i);
        #1 `CHK("int released", 1'b1, int_n);
        wait_low(t2);
        `CHK("expiry spacing", 4096, t2 - t1);
        wr(rfc_pkg::ADR_INT_EN, 8'h00);
        @(posedge clock_i);
        #1 `CHK("int masked", 1'b1, int_n);
        wrap_up();
    end
endmodule // test_rfc_comp_top
